// ==== fifo_core.sv ====
`timescale 1ns/1ps
// Function
// RULE_01: User resets the FIFO after power-up before any write or read.
// RULE_02: Asynchronous reset clears all counters and output registers.
// RULE_03: Write and read reset-busy outputs show when access may start.
// RULE_04: With sync enabled, reset is synchronised into the clock domain.
// RULE_05: Without sync, each side stays in reset while its own reset holds.
// RULE_06: Write when not full stores the word and raises write acknowledge.
// RULE_07: Write while full is dropped, raises overflow, no acknowledge.
// RULE_08: Almost-full is high when exactly one more write fits.
// RULE_09: Full means no write fits until a word is read.
// RULE_10: Write and read together on a partly filled FIFO keep flags steady. Fall-through mode does not: empty and almost-empty can move.
// RULE_11: A read from a full FIFO clears full; next writes succeed.
// RULE_12: Read when not empty presents the next word and raises valid.
// RULE_13: Read while empty is ignored, raises underflow, drops valid.
// RULE_14: Almost-empty is high when exactly one readable word remains.
// RULE_15: Empty means no read is served until data is written.
// RULE_16: Write and read on empty: write taken, read ignored, underflow next.
// RULE_17: Standard data one cycle after request; fall-through same cycle.
// RULE_18: Fall-through mode is offered by this implementation.
// RULE_19: Fall-through shows the first word unasked, empty low, valid high.
// RULE_20: Fall-through read advances output; last read empties, drops valid.
// RULE_21: Fall-through adds two words of read depth.
// RULE_22: Fall-through empty falls two cycles later than standard mode.
module fifo_core
   import fifo_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic wr_rst_i,
   input wire logic rd_rst_i,
   input wire reg_req_s reg_req_i,
   output logic [31:0] reg_rdata_o,
   input wire logic wr_en_i,
   input wire logic [DATA_W-1:0] din_i,
   output logic wr_ack_o,
   output logic overflow_o,
   output logic almost_full_o,
   output logic full_o,
   output logic wr_rst_busy_o,
   input wire logic rd_en_i,
   output logic [DATA_W-1:0] dout_o,
   output logic valid_o,
   output logic underflow_o,
   output logic almost_empty_o,
   output logic empty_o,
   output logic rd_rst_busy_o
);

   logic [CTRL_W-1:0] ctrl;
   logic ft_mode;
   logic [RSYNC_STAGES-1:0] rsync;
   logic wr_rst;
   logic rd_rst;
   logic fifo_rst;
   logic [DATA_W-1:0] mem [DEPTH];
   logic [PTR_W-1:0] wptr;
   logic [PTR_W-1:0] rptr;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] next_cnt;
   logic [DATA_W-1:0] mid;
   logic mid_v;
   logic out_v;
   logic next_mid_v;
   logic next_out_v;
   logic wr_ok;
   logic rd_ok;
   logic can_rd;
   logic pop;
   logic out_take;
   logic [31:0] stat_word;

   // Assert at once, release two clocks after resetn_i rises
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rsync <= '0;
      end else begin
         rsync <= {rsync[0], 1'b1}; // RULE_04
      end
   end

   assign wr_rst = ctrl[CTRL_RSYNC_BIT] ? !rsync[1] : wr_rst_i; // RULE_05
   assign rd_rst = ctrl[CTRL_RSYNC_BIT] ? !rsync[1] : rd_rst_i; // RULE_05
   // One queue serves both sides, so either reset empties it
   assign fifo_rst = wr_rst | rd_rst;

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_rst_busy_o <= 1'b1;
         rd_rst_busy_o <= 1'b1;
      end else begin
         wr_rst_busy_o <= wr_rst; // RULE_03
         rd_rst_busy_o <= rd_rst; // RULE_03
      end
   end

   // Mode is taken only while in reset so a live queue never changes shape
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ft_mode <= 1'b0;
      end else if (fifo_rst) begin
         ft_mode <= ctrl[CTRL_FT_BIT]; // RULE_18
      end
   end

   always_comb begin
      wr_ok = wr_en_i & !full_o & !fifo_rst; // RULE_06 RULE_11
      can_rd = ft_mode ? out_v : (cnt != CNT_ZERO);
      rd_ok = rd_en_i & can_rd & !fifo_rst; // RULE_13
      out_take = ft_mode & mid_v & (!out_v | rd_ok); // RULE_20
      if (ft_mode) begin
         pop = (cnt != CNT_ZERO) & (!mid_v | out_take); // RULE_19
      end else begin
         pop = rd_ok;
      end
      next_cnt = cnt + CNT_W'(wr_ok) - CNT_W'(pop);
      next_out_v = out_take | (out_v & !rd_ok);
      next_mid_v = (ft_mode & pop) | (mid_v & !out_take); // RULE_21
   end

   always_ff @(posedge core_clk_i) begin
      if (wr_ok) begin
         mem[wptr] <= din_i; // RULE_06
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wptr <= '0; // RULE_02
         rptr <= '0;
         cnt <= '0;
      end else if (fifo_rst) begin
         wptr <= '0;
         rptr <= '0;
         cnt <= '0;
      end else begin
         if (wr_ok) begin
            wptr <= wptr + PTR_ONE;
         end
         if (pop) begin
            rptr <= rptr + PTR_ONE;
         end
         cnt <= next_cnt;
      end
   end

   // Two prefetch stages give fall-through its extra depth and latency
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         mid <= '0;
         mid_v <= 1'b0;
         out_v <= 1'b0;
      end else if (fifo_rst) begin
         mid <= '0;
         mid_v <= 1'b0;
         out_v <= 1'b0;
      end else begin
         if (ft_mode && pop) begin
            mid <= mem[rptr]; // RULE_22
         end
         mid_v <= next_mid_v; // RULE_21
         out_v <= next_out_v;
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         dout_o <= '0; // RULE_02
      end else if (fifo_rst) begin
         dout_o <= '0;
      end else if (!ft_mode && rd_ok) begin
         dout_o <= mem[rptr]; // RULE_12 RULE_17
      end else if (out_take) begin
         dout_o <= mid; // RULE_17 RULE_19
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_ack_o <= 1'b0;
         overflow_o <= 1'b0;
         full_o <= 1'b0;
         almost_full_o <= 1'b0;
      end else if (fifo_rst) begin
         wr_ack_o <= 1'b0;
         overflow_o <= 1'b0;
         full_o <= 1'b0;
         almost_full_o <= 1'b0;
      end else begin
         wr_ack_o <= wr_ok; // RULE_06
         overflow_o <= wr_en_i & full_o; // RULE_07
         full_o <= (next_cnt == CNT_FULL); // RULE_09 RULE_11
         almost_full_o <= (next_cnt == CNT_AFULL); // RULE_08 RULE_10
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         valid_o <= 1'b0;
         underflow_o <= 1'b0;
         empty_o <= 1'b1;
         almost_empty_o <= 1'b0;
      end else if (fifo_rst) begin
         valid_o <= 1'b0;
         underflow_o <= 1'b0;
         empty_o <= 1'b1;
         almost_empty_o <= 1'b0;
      end else begin
         underflow_o <= rd_en_i & !can_rd; // RULE_13 RULE_16
         if (ft_mode) begin
            valid_o <= next_out_v; // RULE_19 RULE_20
            empty_o <= !next_out_v; // RULE_20 RULE_22
            almost_empty_o <= next_out_v & !next_mid_v &
                              (next_cnt == CNT_ZERO); // RULE_14
         end else begin
            valid_o <= rd_ok; // RULE_12
            empty_o <= (next_cnt == CNT_ZERO); // RULE_15 RULE_16
            almost_empty_o <= (next_cnt == CNT_ONE); // RULE_14
         end
      end
   end

   // Register port: control steers reset and mode, status mirrors flags
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl <= CTRL_RESET;
      end else if (reg_req_i.wr && reg_req_i.addr == CTRL_ADDR) begin
         ctrl <= reg_req_i.wdata[CTRL_W-1:0];
      end
   end

   always_comb begin
      stat_word = '0;
      stat_word[STAT_FULL_BIT] = full_o;
      stat_word[STAT_AFULL_BIT] = almost_full_o;
      stat_word[STAT_EMPTY_BIT] = empty_o;
      stat_word[STAT_AEMPTY_BIT] = almost_empty_o;
      stat_word[STAT_WBUSY_BIT] = wr_rst_busy_o;
      stat_word[STAT_RBUSY_BIT] = rd_rst_busy_o;
      stat_word[STAT_FT_BIT] = ft_mode;
      stat_word[STAT_CNT_LSB +: CNT_W] = cnt;
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= '0;
      end else if (reg_req_i.rd) begin
         case (reg_req_i.addr)
            CTRL_ADDR: begin
               reg_rdata_o <= {{(32-CTRL_W){1'b0}}, ctrl};
            end
            STAT_ADDR: begin
               reg_rdata_o <= stat_word;
            end
            default: begin
               reg_rdata_o <= '0;
            end
         endcase
      end else begin
         reg_rdata_o <= '0;
      end
   end

   // Checks
   logic quiet;
   assign quiet = !fifo_rst;

   property p_reset_clear;
      @(posedge core_clk_i) disable iff (!resetn_i)
      $rose(resetn_i) |-> empty_o && !full_o && !valid_o && cnt == CNT_ZERO;
   endproperty
   a_reset_clear: assert property (p_reset_clear) // RULE_02
      else $error("state not cleared by reset");

   property p_busy;
      @(posedge core_clk_i) disable iff (!resetn_i)
      !ctrl[CTRL_RSYNC_BIT] && wr_rst_i |=> wr_rst_busy_o;
   endproperty
   a_busy: assert property (p_busy) // RULE_03
      else $error("write reset busy missing");

   property p_wr_ack;
      @(posedge core_clk_i) disable iff (!resetn_i)
      quiet && wr_en_i && !full_o |=> wr_ack_o && !overflow_o;
   endproperty
   a_wr_ack: assert property (p_wr_ack) // RULE_06
      else $error("accepted write not acknowledged");

   property p_overflow;
      @(posedge core_clk_i) disable iff (!resetn_i)
      quiet && wr_en_i && full_o |=> overflow_o && !wr_ack_o
         && cnt == $past(cnt) - CNT_W'($past(pop));
   endproperty
   a_overflow: assert property (p_overflow) // RULE_07
      else $error("overflow not flagged");

   property p_afull;
      @(posedge core_clk_i) disable iff (!resetn_i)
      almost_full_o |-> cnt == CNT_AFULL;
   endproperty
   a_afull: assert property (p_afull) // RULE_08
      else $error("almost full wrong level");

   property p_full;
      @(posedge core_clk_i) disable iff (!resetn_i)
      quiet && full_o && !rd_en_i |=> full_o;
   endproperty
   a_full: assert property (p_full) // RULE_09
      else $error("full dropped without read");

   property p_steady;
      @(posedge core_clk_i) disable iff (!resetn_i)
      quiet && !ft_mode && wr_en_i && rd_en_i && !empty_o && !full_o
      |=> $stable(full_o) && $stable(empty_o) && $stable(almost_full_o)
          && $stable(almost_empty_o);
   endproperty
   a_steady: assert property (p_steady) // RULE_10
      else $error("flags moved on paired access");

   property p_std_read;
      @(posedge core_clk_i) disable iff (!resetn_i)
      quiet && !ft_mode && rd_en_i && !empty_o
      |=> valid_o && dout_o == $past(mem[rptr]);
   endproperty
   a_std_read: assert property (p_std_read) // RULE_12
      else $error("standard read data wrong");

   property p_underflow;
      @(posedge core_clk_i) disable iff (!resetn_i)
      quiet && rd_en_i && empty_o |=> underflow_o && !valid_o;
   endproperty
   a_underflow: assert property (p_underflow) // RULE_13
      else $error("underflow not flagged");

   property p_empty_pair;
      @(posedge core_clk_i) disable iff (!resetn_i)
      quiet && !ft_mode && wr_en_i && rd_en_i && empty_o
      |=> !empty_o && underflow_o && wr_ack_o;
   endproperty
   a_empty_pair: assert property (p_empty_pair) // RULE_16
      else $error("write with read on empty wrong");

   property p_ft_valid;
      @(posedge core_clk_i) disable iff (!resetn_i)
      ft_mode && quiet |-> valid_o == !empty_o;
   endproperty
   a_ft_valid: assert property (p_ft_valid) // RULE_19
      else $error("fall-through valid and empty disagree");

   property p_ft_latency;
      @(posedge core_clk_i) disable iff (!resetn_i)
      ft_mode && !wr_rst_i && !rd_rst_i && quiet && empty_o && !mid_v
      && cnt == CNT_ZERO && wr_en_i
      |=> empty_o ##1 empty_o ##1 !empty_o;
   endproperty
   a_ft_latency: assert property (p_ft_latency) // RULE_22
      else $error("fall-through empty timing wrong");

   c_full: cover property (@(posedge core_clk_i) $rose(full_o));
   c_ft_read: cover property (@(posedge core_clk_i)
      ft_mode && valid_o && rd_en_i);
   c_under: cover property (@(posedge core_clk_i) underflow_o);
   c_over: cover property (@(posedge core_clk_i) overflow_o);
endmodule

// ==== fifo_core_flags_and_read_modes_bench.sv ====
`timescale 1ns/1ps
module fifo_core_flags_and_read_modes_bench;
   import fifo_pkg::*;
   logic core_clk_i, resetn_i, wr_rst_i, rd_rst_i;
   reg_req_s req;
   logic [31:0] rdata, d;
   logic wr_en, rd_en, wr_ack, ovf, afull, full, wbusy;
   logic valid, unf, aempty, empty, rbusy;
   logic [DATA_W-1:0] din, dout;
   int fails = 0;
   int total_checks = 0;
   fifo_core fifo_core_i(.core_clk_i(core_clk_i), .resetn_i(resetn_i),
      .wr_rst_i(wr_rst_i), .rd_rst_i(rd_rst_i), .reg_req_i(req),
      .reg_rdata_o(rdata), .wr_en_i(wr_en), .din_i(din), .wr_ack_o(wr_ack),
      .overflow_o(ovf), .almost_full_o(afull), .full_o(full),
      .wr_rst_busy_o(wbusy), .rd_en_i(rd_en), .dout_o(dout),
      .valid_o(valid), .underflow_o(unf), .almost_empty_o(aempty),
      .empty_o(empty), .rd_rst_busy_o(rbusy));
   fifo_user fifo_user_i(.clk_i(core_clk_i), .wr_en_o(wr_en), .din_o(din),
      .rd_en_o(rd_en));
   initial begin
      core_clk_i = 1'b0;
      forever #10 core_clk_i = ~core_clk_i;
   end
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk_i);
      req.addr <= a;
      req.wdata <= v;
      req.wr <= 1'b1;
      @(posedge core_clk_i);
      req.wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk_i);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge core_clk_i);
      req.rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      while ((wbusy !== 1'b0 || rbusy !== 1'b0) && n < 20) begin
         @(posedge core_clk_i);
         #1 n++;
      end
      chk("ready", 1, n < 20);
   endtask
   task automatic flags(input logic [3:0] e);
      chk("full afull empty aempty", {28'h0, e}, {full, afull, empty, aempty});
   endtask
   initial begin
      #100000;
      fails++;
      tally_and_finish();
   end
   initial begin
      resetn_i = 1'b0;
      wr_rst_i = 1'b0;
      rd_rst_i = 1'b0;
      req = '0;
      repeat (3) @(posedge core_clk_i);
      #1 flags(4'h2);
      chk("busy", 2'h3, {wbusy, rbusy});
      chk("reset flags", 0, {wr_ack, ovf, valid, unf, dout});
      @(posedge core_clk_i);
      resetn_i <= 1'b1;
      wait_ready();
      // Nothing is requested before busy falls
      reg_rd(CTRL_ADDR, d);
      chk("ctrl", {30'h0, CTRL_RESET}, d);
      reg_rd(8'h08, d);
      chk("unmapped", 0, d);
      fifo_user_i.xfer(1'b1, 8'ha0, 1'b0);
      chk("ack", 1, wr_ack);
      flags(4'h1);
      fifo_user_i.xfer(1'b1, 8'ha1, 1'b1);
      flags(4'h1);
      chk("dout", 9'h1a0, {valid, dout});
      chk("valid", 1, valid);
      for (int i = 2; i < 17; i++) begin
         fifo_user_i.xfer(1'b1, 8'(8'ha0 + i), 1'b0);
         chk("afull", i == 15, afull);
         chk("full", i == 16, full);
      end
      reg_rd(STAT_ADDR, d);
      chk("count", {27'h0, CNT_FULL}, {27'h0, d[STAT_CNT_LSB+:CNT_W]});
      fifo_user_i.xfer(1'b1, 8'hee, 1'b0);
      chk("ack ovf", 2'h1, {wr_ack, ovf});
      flags(4'h8);
      fifo_user_i.xfer(1'b0, 8'h00, 1'b1);
      chk("dout", 8'ha1, dout);
      flags(4'h4);
      fifo_user_i.xfer(1'b1, 8'hb0, 1'b0);
      chk("ack ovf", 2'h2, {wr_ack, ovf});
      for (int i = 2; i < 18; i++) begin
         fifo_user_i.xfer(1'b0, 8'h00, 1'b1);
         chk("dout", (i < 17) ? 8'(8'ha0 + i) : 8'hb0, dout);
         chk("valid", 1, valid);
         chk("aempty", i == 16, aempty);
      end
      chk("empty", 1, empty);
      fifo_user_i.xfer(1'b0, 8'h00, 1'b1);
      chk("unf valid", 2'h2, {unf, valid});
      chk("empty", 1, empty);
      fifo_user_i.xfer(1'b1, 8'hc0, 1'b1);
      chk("unf empty ack", 3'h5, {unf, empty, wr_ack});
      fifo_user_i.xfer(1'b0, 8'h00, 1'b1);
      chk("dout", 8'hc0, dout);
      reg_wr(CTRL_ADDR, 32'h1);
      wr_rst_i <= 1'b1;
      rd_rst_i <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      #1 chk("busy held", 2'h3, {wbusy, rbusy});
      @(posedge core_clk_i);
      wr_rst_i <= 1'b0;
      rd_rst_i <= 1'b0;
      wait_ready();
      reg_rd(STAT_ADDR, d);
      chk("ft mode", 1, d[STAT_FT_BIT]);
      fifo_user_i.xfer(1'b1, 8'hd0, 1'b0);
      chk("empty", 1, empty);
      @(posedge core_clk_i);
      #1 chk("empty", 1, empty);
      @(posedge core_clk_i);
      #1 chk("ft word", 10'h1d0, {empty, valid, dout});
      fifo_user_i.xfer(1'b0, 8'h00, 1'b1);
      chk("empty valid", 2'h2, {empty, valid});
      fifo_user_i.xfer(1'b0, 8'h00, 1'b1);
      chk("unf", 1, unf);
      for (int i = 0; i < 18; i++) begin
         fifo_user_i.xfer(1'b1, 8'(i), 1'b0);
         chk("ack", 1, wr_ack);
         repeat (3) @(posedge core_clk_i);
      end
      fifo_user_i.xfer(1'b1, 8'hff, 1'b0);
      chk("ovf", 1, ovf);
      for (int i = 0; i < 18; i++) begin
         chk("ft dout", {1'b1, 8'(i)}, {valid, dout});
         chk("ft aempty", i == 17, aempty);
         fifo_user_i.xfer(1'b0, 8'h00, 1'b1);
      end
      chk("empty valid", 2'h2, {empty, valid});
      tally_and_finish();
   end
endmodule

// ==== fifo_pkg.sv ====
package fifo_pkg;
   // Data width and depth have no fixed figure; plain defaults
   localparam int DATA_W = 8;
   localparam int DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
   localparam logic [CNT_W-1:0] CNT_AFULL = 5'h0f;
   localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
   localparam logic [PTR_W-1:0] PTR_ONE = 4'h1;

   // Register map, byte addresses
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STAT_ADDR = 8'h04;
   localparam int CTRL_W = 2;
   localparam int CTRL_FT_BIT = 0;
   localparam int CTRL_RSYNC_BIT = 1;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h2;
   localparam int STAT_FULL_BIT = 0;
   localparam int STAT_AFULL_BIT = 1;
   localparam int STAT_EMPTY_BIT = 2;
   localparam int STAT_AEMPTY_BIT = 3;
   localparam int STAT_WBUSY_BIT = 4;
   localparam int STAT_RBUSY_BIT = 5;
   localparam int STAT_FT_BIT = 6;
   localparam int STAT_CNT_LSB = 8;

   // Reset synchroniser length in clock cycles
   localparam int RSYNC_STAGES = 2;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;
endpackage

// ==== fifo_user.sv ====
`timescale 1ns/1ps
module fifo_user
   import fifo_pkg::*;
(
   input wire logic clk_i,
   output logic wr_en_o,
   output logic [DATA_W-1:0] din_o,
   output logic rd_en_o
);
   initial begin
      wr_en_o = 1'b0;
      din_o = '0;
      rd_en_o = 1'b0;
   end
   // One request cycle per call; callers add idle cycles to go slowly
   task automatic xfer(input logic w, input logic [DATA_W-1:0] d,
                       input logic r);
      @(posedge clk_i);
      wr_en_o <= w;
      din_o <= d;
      rd_en_o <= r;
      @(posedge clk_i);
      wr_en_o <= 1'b0;
      rd_en_o <= 1'b0;
      // Released data shows the inverse so a stale word cannot match
      din_o <= ~d;
      #1;
   endtask
endmodule
